// >>> logic/adc_serial_port_signalling.v
// Serial host port of a sigma-delta converter with its result buffer.
// Summary of operation
// - Drive word-ready low once a fresh result sits in the result register.
// - Release word-ready high when the host has shifted out a whole result word.
// - Unread result replaced: pulse word-ready high, length set by filter/clock bits.
// - Raw-bitstream select set: serial output carries the modulator bitstream.
// - Raw-bitstream select set: word-ready becomes the output bit strobe.
// - Reads shift out command, setup, transfer or result register from a shift register.
// - Input bits collect in a shift register, then go to the selected register.
// - Serial clock may run continuously or in bursts.
// - With chip select framing, clock idle level at select fall sets active edge.
// - While scanning, each result word carries the producing channel tag.
// - Each transaction starts with a command write opening with a 0 start bit.
// - Three select bits pick one of eight registers, 0 command, 7 result.
// - Thirty-two consecutive ones return the port to awaiting a command.
// - The port responds only while chip select is low.
`timescale 1ns/1ns
`default_nettype none
`include "serial_port_consts.vh"

////////////////////////////////////////////////////////////////////////////////
// Result buffer: flip-flop FIFO between the converter and the result register.
module result_fifo #(
  parameter W = 21,
  parameter D = 8,
  parameter AW = 3
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire in_valid_i,
  input wire [W-1:0] in_data_i,
  output wire in_ready_o,
  output wire out_valid_o,
  output wire [W-1:0] out_data_o,
  input wire out_ready_i
);
  reg [W-1:0] mem_reg [0:D-1];
  reg [AW-1:0] wr_reg;
  reg [AW-1:0] rd_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;
  // Full and empty come straight from the fill count.
  assign in_ready_o = (count_reg != D[AW:0]);
  assign out_valid_o = (count_reg != {(AW+1){1'b0}});
  assign out_data_o = mem_reg[rd_reg];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  // Storage is written only on a push, so it needs no reset.
  always @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data_i;
    end
  end
  // Pointers wrap at the depth, which need not be a power of two.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_reg + 1'b1;
      end
      count_reg <= count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Serial port top level.
module adc_serial_port_signalling #(
  parameter RES_W = 18,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  input wire clk_i,
  input wire resetn_i,
  input wire cs_n_i,
  input wire sclk_i,
  input wire din_i,
  output wire dout_o,
  output wire dout_oe_o,
  output wire int_n_o,
  input wire conv_valid_i,
  input wire [RES_W-1:0] conv_result_i,
  input wire [2:0] conv_chan_i,
  output wire conv_ready_o,
  input wire mod_bit_i,
  input wire mod_strobe_i,
  output wire [7:0] setup1_o,
  output wire [7:0] setup2_o,
  output wire [7:0] special_o,
  output wire [7:0] xfer1_o,
  output wire [7:0] xfer2_o,
  output wire [7:0] xfer3_o
);
  localparam ST_CMD = 2'h0;
  localparam ST_WR = 2'h1;
  localparam ST_RD = 2'h2;
  localparam FW = RES_W + 3;
  localparam SW = RES_W + 6;

  reg rst_a_reg;
  reg rst_n;
  reg [2:0] cs_sync_reg;
  reg [2:0] sclk_sync_reg;
  reg [1:0] din_sync_reg;
  reg cpol_reg;
  reg [1:0] state_reg;
  reg [4:0] cnt_reg;
  reg [5:0] ones_reg;
  reg [6:0] in_shift_reg;
  reg [7:0] command_word_register;
  reg [7:0] cfg_reg [1:6];
  reg [SW-1:0] out_shift_reg;
  reg [4:0] rd_len_reg;
  reg rd_result_reg;
  reg dout_reg;
  reg read_done_reg;
  reg [SW-1:0] result_reg;
  reg drdy_reg;
  reg [7:0] blank_reg;
  wire cs_s;
  wire sclk_s;
  wire din_s;
  wire cs_fall;
  wire sclk_rise;
  wire sclk_fall;
  wire sample_e;
  wire launch_e;
  wire [7:0] cmd_word;
  wire [2:0] sel;
  wire raw_bitstream_select;
  wire scan_on;
  wire fifo_valid;
  wire [FW-1:0] fifo_data;
  wire fifo_pop;
  integer i;

  // Reset is asserted at once and released through two flip-flops.
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_a_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a_reg <= 1'b1;
      rst_n <= rst_a_reg;
    end
  end

  // Pin synchronisers; the third stage of select and clock only feeds edge detection.
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync_reg <= 3'h7;
      sclk_sync_reg <= 3'h7;
      din_sync_reg <= 2'h3;
    end else begin
      cs_sync_reg <= {cs_sync_reg[1:0], cs_n_i};
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_i};
      din_sync_reg <= {din_sync_reg[0], din_i};
    end
  end

  assign cs_s = cs_sync_reg[1];
  assign sclk_s = sclk_sync_reg[1];
  assign din_s = din_sync_reg[1];
  assign cs_fall = cs_sync_reg[2] & ~cs_s;
  // Edges are found by sampling, so the serial clock may stop between bursts.
  assign sclk_rise = ~sclk_sync_reg[2] & sclk_s;
  assign sclk_fall = sclk_sync_reg[2] & ~sclk_s;
  // Idle high samples on rising and launches on falling; idle low swaps them.
  assign sample_e = ~cs_s & (cpol_reg ? sclk_rise : sclk_fall);
  assign launch_e = ~cs_s & (cpol_reg ? sclk_fall : sclk_rise);
  assign cmd_word = {in_shift_reg, din_s};
  assign sel = cmd_word[`CMD_SEL_HI:`CMD_SEL_LO];
  assign raw_bitstream_select = cfg_reg[`SEL_SPECIAL][`RAW_SEL_BIT];
  assign scan_on = cfg_reg[1][`SCAN_BIT];
  assign setup1_o = cfg_reg[1];
  assign setup2_o = cfg_reg[2];
  assign special_o = cfg_reg[3];
  assign xfer1_o = cfg_reg[4];
  assign xfer2_o = cfg_reg[5];
  assign xfer3_o = cfg_reg[6];

  ////////////////////////////////////////////////////////////////////////////////
  // Serial engine: command decode, register writes and reads.
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cpol_reg <= 1'b1;
      state_reg <= ST_CMD;
      cnt_reg <= 5'h00;
      ones_reg <= 6'h00;
      in_shift_reg <= 7'h00;
      command_word_register <= `CFG_RESET;
      for (i = 1; i < 7; i = i + 1) begin
        cfg_reg[i] <= `CFG_RESET;
      end
      out_shift_reg <= {SW{1'b0}};
      rd_len_reg <= `REG_BITS;
      rd_result_reg <= 1'b0;
      dout_reg <= 1'b1;
      read_done_reg <= 1'b0;
    end else begin
      read_done_reg <= 1'b0;
      if (cs_s) begin
        // Deselected: the frame is abandoned and the next one starts with a command.
        state_reg <= ST_CMD;
        cnt_reg <= 5'h00;
        ones_reg <= 6'h00;
      end else begin
        if (cs_fall) begin
          cpol_reg <= sclk_s;
        end
        if (launch_e && state_reg == ST_RD) begin
          dout_reg <= out_shift_reg[SW-1];
          out_shift_reg <= {out_shift_reg[SW-2:0], 1'b0};
        end
        if (sample_e) begin
          ones_reg <= din_s ? ones_reg + 6'h01 : 6'h00;
          if (din_s && ones_reg == `ONES_TO_RESET - 6'h01) begin
            // Interface reset leaves every register untouched.
            state_reg <= ST_CMD;
            cnt_reg <= 5'h00;
            ones_reg <= 6'h00;
          end else begin
            case (state_reg)
              ST_CMD: begin
                // Ones while idle are ignored until a 0 start bit arrives.
                if (cnt_reg != 5'h00 || !din_s) begin
                  in_shift_reg <= {in_shift_reg[5:0], din_s};
                  cnt_reg <= cnt_reg + 5'h01;
                end
                if (cnt_reg == `REG_BITS - 5'h01) begin
                  cnt_reg <= 5'h00;
                  command_word_register <= cmd_word;
                  if (cmd_word[`CMD_RW_BIT]) begin
                    // Reads are refused while the raw bitstream owns the output.
                    if (!raw_bitstream_select) begin
                      state_reg <= ST_RD;
                      rd_result_reg <= (sel == `SEL_RESULT);
                      rd_len_reg <= (sel == `SEL_RESULT) ? `RESULT_BITS : `REG_BITS;
                      if (sel == `SEL_RESULT) begin
                        out_shift_reg <= result_reg;
                      end else if (sel == `SEL_COMMAND) begin
                        out_shift_reg <= {drdy_reg, cmd_word[6:0], {(SW-8){1'b0}}};
                      end else begin
                        out_shift_reg <= {cfg_reg[sel], {(SW-8){1'b0}}};
                      end
                    end
                  end else if (sel != `SEL_COMMAND && sel != `SEL_RESULT) begin
                    state_reg <= ST_WR;
                  end
                end
              end
              ST_WR: begin
                in_shift_reg <= {in_shift_reg[5:0], din_s};
                cnt_reg <= cnt_reg + 5'h01;
                if (cnt_reg == `REG_BITS - 5'h01) begin
                  cfg_reg[command_word_register[`CMD_SEL_HI:`CMD_SEL_LO]] <= cmd_word;
                  cnt_reg <= 5'h00;
                  state_reg <= ST_CMD;
                end
              end
              ST_RD: begin
                cnt_reg <= cnt_reg + 5'h01;
                if (cnt_reg == rd_len_reg - 5'h01) begin
                  read_done_reg <= rd_result_reg;
                  cnt_reg <= 5'h00;
                  state_reg <= ST_CMD;
                end
              end
              default: begin
                state_reg <= ST_CMD;
                cnt_reg <= 5'h00;
              end
            endcase
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Result register and word-ready flag.
  // The buffer stalls while a result is being shifted out, so the word in flight is
  // never torn; conversions then back up into the buffer and finally the source.
  assign fifo_pop = fifo_valid & ~(state_reg == ST_RD && rd_result_reg);
  result_fifo #(
    .W(FW),
    .D(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .in_valid_i(conv_valid_i),
    .in_data_i({conv_result_i, conv_chan_i}),
    .in_ready_o(conv_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(fifo_pop)
  );
  // A new result sets the flag even in the cycle a finished read clears it.
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      result_reg <= {SW{1'b0}};
      drdy_reg <= 1'b0;
      blank_reg <= 8'h00;
    end else begin
      if (blank_reg != 8'h00) begin
        blank_reg <= blank_reg - 8'h01;
      end
      if (read_done_reg) begin
        drdy_reg <= 1'b0;
      end
      if (fifo_pop) begin
        result_reg <= {fifo_data[FW-1:3], scan_on ? fifo_data[2:0] : `NO_TAG, `RESULT_PAD};
        drdy_reg <= 1'b1;
        if (drdy_reg && !read_done_reg) begin
          blank_reg <= `BLANK_BASE << cfg_reg[4][`BLANK_HI:`BLANK_LO];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin outputs. The output is driven only during reads or in raw mode.
  assign dout_o = raw_bitstream_select ? mod_bit_i : dout_reg;
  assign dout_oe_o = ~cs_s & (raw_bitstream_select | (state_reg == ST_RD));
  // Low means a result waits; high signals activity, when the host must not read.
  assign int_n_o = raw_bitstream_select ? mod_strobe_i : (~drdy_reg | (blank_reg != 8'h00));
endmodule
`default_nettype wire

// >>> logic/serial_port_consts.vh
// Constants shared by the converter serial port and its result buffer.
`ifndef SERIAL_PORT_CONSTS_VH
`define SERIAL_PORT_CONSTS_VH
// Command word layout, first bit shifted in is bit 7.
`define CMD_START_BIT 7
`define CMD_SEL_HI 6
`define CMD_SEL_LO 4
`define CMD_RW_BIT 3
// Register select codes.
`define SEL_COMMAND 3'h0
`define SEL_SPECIAL 3'h3
`define SEL_RESULT 3'h7
// Configuration register reset value.
`define CFG_RESET 8'h00
// Raw bitstream select bit inside the special function register.
`define RAW_SEL_BIT 0
// Scan enable bit inside global setup register 1.
`define SCAN_BIT 0
// Filter/clock field of transfer register 1 that stretches the ready blank.
`define BLANK_HI 1
`define BLANK_LO 0
`define BLANK_BASE 8'h04
// Bit counts of the serial frames.
`define REG_BITS 5'h08
`define RESULT_BITS 5'h18
`define ONES_TO_RESET 6'h20
// Padding below the channel tag in the result word.
`define RESULT_PAD 3'h0
`define NO_TAG 3'h0
`endif

// >>> test/host_model.sv
// Serial master model standing in for the host processor.
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic dout_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic din_o
);
  // Idle with select high, clock high and data high before the first frame.
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b1;
    din_o = 1'b1;
  end
  // One framed burst; the clock stands still between bursts.
  task automatic xfer(input logic pol, input logic [55:0] tx, input int n, output logic [31:0] rx);
    sclk_o = pol;
    #400 cs_n_o = 1'b0;
    #400;
    for (int i = n - 1; i >= 0; i--) begin
      din_o = tx[i];
      sclk_o = ~pol;
      #400 rx = {rx[30:0], dout_i};
      sclk_o = pol;
      #400;
    end
    #800 cs_n_o = 1'b1;
    din_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> test/port_properties.sv
// Concurrent checks on the converter serial port pins.
`timescale 1ns/1ns
`default_nettype none
module port_properties (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic dout_o,
  input wire logic dout_oe_o,
  input wire logic int_n_o,
  input wire logic conv_valid_i,
  input wire logic conv_ready_o,
  input wire logic mod_bit_i,
  input wire logic mod_strobe_i,
  input wire logic [7:0] setup2_o,
  input wire logic [7:0] special_o,
  input wire logic [7:0] xfer1_o
);
  logic [3:0] acc_reg;
  logic pol_reg;
  // Count accepted results and keep the clock level seen at each select fall.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_reg <= 4'h0;
      pol_reg <= 1'b1;
    end else begin
      if (conv_valid_i && conv_ready_o && acc_reg != 4'hF)
        acc_reg <= acc_reg + 4'h1;
      if ($fell(cs_n_i))
        pol_reg <= sclk_i;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence deselected_seq;
    cs_n_i [*4];
  endsequence
  sequence blank_seq;
    int_n_o [*4];
  endsequence
  deselect_quiet_a: assert property (deselected_seq |-> !dout_oe_o)
    else $error("serial output enabled while deselected");
  raw_data_a: assert property (special_o[0] |-> dout_o == mod_bit_i)
    else $error("raw bit not on serial output");
  raw_strobe_a: assert property (special_o[0] |-> int_n_o == mod_strobe_i)
    else $error("raw strobe not on ready output");
  ready_cause_a: assert property ($fell(int_n_o) && !special_o[0] && !$past(special_o[0]) |-> acc_reg != 4'h0)
    else $error("ready without any result");
  blank_len_a: assert property ($rose(int_n_o) && cs_n_i && !special_o[0] && !$past(special_o[0])
    && xfer1_o[1:0] == 2'h0 |-> blank_seq)
    else $error("ready blank pulse too short");
  buffer_depth_a: assert property (!conv_ready_o |-> acc_reg >= 4'h8)
    else $error("buffer refused before eight words");
  launch_edge_a: assert property (dout_oe_o && $past(dout_oe_o) && !special_o[0] && $changed(dout_o)
    |-> sclk_i != pol_reg)
    else $error("serial output changed in sample phase");
  write_framed_a: assert property ($changed({setup2_o, special_o, xfer1_o}) |-> !$past(cs_n_i, 2))
    else $error("register changed outside a frame");
endmodule
bind adc_serial_port_signalling port_properties i_props (.clk_i(clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n_i),
  .sclk_i(sclk_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o), .int_n_o(int_n_o), .conv_valid_i(conv_valid_i),
  .conv_ready_o(conv_ready_o), .mod_bit_i(mod_bit_i), .mod_strobe_i(mod_strobe_i), .setup2_o(setup2_o),
  .special_o(special_o), .xfer1_o(xfer1_o));
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for the converter serial port.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic conv_valid_i = 1'b0;
  logic [17:0] conv_result_i = 18'h00000;
  logic [2:0] conv_chan_i = 3'h0;
  logic mod_bit_i = 1'b0;
  logic mod_strobe_i = 1'b1;
  wire cs_n, sclk, din, dout, dout_oe, int_n, conv_ready;
  // A released serial output shows the inverse of its last level, so a late enable is caught.
  wire dout_line = dout_oe ? dout : ~dout;
  wire [7:0] cfg [0:5];
  int bad_count = 0;
  int check_count = 0;
  logic [31:0] rx;
  adc_serial_port_signalling i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n), .sclk_i(sclk), .din_i(din),
    .dout_o(dout), .dout_oe_o(dout_oe), .int_n_o(int_n), .conv_valid_i(conv_valid_i), .conv_result_i(conv_result_i),
    .conv_chan_i(conv_chan_i), .conv_ready_o(conv_ready), .mod_bit_i(mod_bit_i), .mod_strobe_i(mod_strobe_i),
    .setup1_o(cfg[0]), .setup2_o(cfg[1]), .special_o(cfg[2]), .xfer1_o(cfg[3]), .xfer2_o(cfg[4]), .xfer3_o(cfg[5]));
  host_model i_host (.dout_i(dout_line), .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din));
  initial forever #50 clk_i = ~clk_i;
  // Inputs move 1 ns after the rising edge so the design never races them.
  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wait_int(input logic lvl);
    int n;
    n = 0;
    while (int_n !== lvl && n < 400) begin
      tick();
      n++;
    end
    check("ready level", int_n, lvl);
  endtask
  task automatic wr(input logic [2:0] sel, input logic [7:0] v, input logic pol);
    i_host.xfer(pol, {40'h0, 1'b0, sel, 4'h0, v}, 16, rx);
  endtask
  // The command goes out first, then the host holds the data line high while the word comes back.
  task automatic rd_pol(input logic [2:0] sel, input int n, input logic pol);
    i_host.xfer(pol, (56'({1'b0, sel, 4'h8}) << n) | ((56'h1 << n) - 56'h1), 8 + n, rx);
  endtask
  task automatic rd(input logic [2:0] sel, input int n);
    rd_pol(sel, n, 1'b1);
  endtask
  // Hold valid until the buffer shows room, then release after the taking edge.
  task automatic push(input logic [17:0] r, input logic [2:0] ch);
    conv_result_i = r;
    conv_chan_i = ch;
    conv_valid_i = 1'b1;
    while (conv_ready !== 1'b1) tick();
    tick();
    conv_valid_i = 1'b0;
  endtask
  // Register codes 0 to 6, alternating clock polarity from one register to the next.
  task automatic t_regs;
    logic [7:0] v;
    for (int c = 1; c <= 6; c++) begin
      v = 8'h0C + 8'(c) * 8'h10;
      wr(3'(c), v, c[0]);
      rd_pol(3'(c), 8, c[0]);
      check("read back", rx[7:0], v);
      check("register port", cfg[c-1], v);
    end
    rd(3'h0, 8);
    check("command read", rx[7:0], 8'h08);
    $display("register test done");
  endtask
  task automatic t_result;
    int hi;
    push(18'h2A5C3, 3'h5);
    wait_int(1'b0);
    rd(3'h7, 24);
    check("plain result", rx[23:0], {18'h2A5C3, 6'h00});
    wait_int(1'b1);
    wr(3'h1, 8'h01, 1'b1);
    push(18'h1F00E, 3'h6);
    wait_int(1'b0);
    push(18'h0ABCD, 3'h2);
    wait_int(1'b1);
    hi = 0;
    while (int_n === 1'b1 && hi < 40) begin
      tick();
      hi++;
    end
    check("blank length", hi, 4);
    rd(3'h7, 24);
    check("tagged result", rx[23:0], {18'h0ABCD, 3'h2, 3'h0});
    $display("result test done");
  endtask
  // A result read stalls the buffer until it refuses, then it drains.
  task automatic t_fifo;
    int k;
    k = 0;
    push(18'h00003, 3'h1);
    wait_int(1'b0);
    fork
      rd(3'h7, 24);
      begin
        repeat (100) tick();
        conv_valid_i = 1'b1;
        while (conv_ready === 1'b1 && k < 12) begin
          conv_result_i = 18'(k);
          tick();
          k++;
        end
        conv_valid_i = 1'b0;
      end
    join
    check("stalled result", rx[23:0], {18'h00003, 3'h1, 3'h0});
    check("buffer depth", k, 8);
    repeat (200) tick();
    check("buffer free", conv_ready, 1'b1);
    wait_int(1'b0);
    rd(3'h7, 24);
    check("last buffered", rx[23:0], {18'h00007, 3'h1, 3'h0});
    $display("buffer test done");
  endtask
  task automatic t_raw;
    wr(3'h3, 8'h01, 1'b1);
    for (int i = 0; i < 4; i++) begin
      mod_bit_i = i[0];
      mod_strobe_i = i[1];
      tick();
      check("raw data", dout, i[0]);
      check("raw strobe", int_n, i[1]);
    end
    wr(3'h3, 8'h00, 1'b1);
    check("raw off", cfg[2], 8'h00);
    $display("raw test done");
  endtask
  // A broken command, thirty-two ones, then a clean write in the same frame.
  task automatic t_ones;
    i_host.xfer(1'b1, {3'h0, 5'h03, 32'hFFFFFFFF, 8'h20, 8'h5A}, 53, rx);
    check("kept register", cfg[0], 8'h01);
    check("write after ones", cfg[1], 8'h5A);
    $display("ones test done");
  endtask
  initial begin
    #2000000;
    bad_count++;
    final_report();
  end
  initial begin
    repeat (2) tick();
    resetn_i = 1'b1;
    repeat (4) tick();
    t_regs();
    t_result();
    t_fifo();
    t_raw();
    t_ones();
    resetn_i = 1'b0;
    tick();
    resetn_i = 1'b1;
    repeat (4) tick();
    check("reset clears", cfg[3], 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
